/* hw/ift_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module ift_decoder (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] instr_word_in,
    input wire logic cond_true_in,
    output logic [20:0] fetch_addr_out,
    output logic cycle_strobe_out,
    output logic [1:0] phase_out,
    output logic valid_out,
    output ift_pkg::ift_group_e group_out,
    output logic [7:0] opcode_out,
    output logic [7:0] file_addr_out,
    output logic dest_file_out,
    output logic bank_sel_out,
    output logic [2:0] bit_num_out,
    output logic [1:0] fsr_sel_out,
    output logic [19:0] literal_out,
    output logic fast_out,
    output ift_pkg::ift_tbl_e tbl_mode_out,
    output logic two_word_out,
    output logic is_nop_out,
    output logic extended_out,
    output logic [1:0] exec_cycles_out
);
    import ift_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // phase counter: instruction cycle of four oscillator periods
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic cyc_reg;
    logic cyc_next;

    always_comb begin
        phase_next = phase_reg + 2'h1; // [RULE_20] [RULE_14]
        cyc_next = (phase_reg == PHASE_LAST) ? 1'b1 : 1'b0;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_reg <= 2'h0;
            cyc_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            cyc_reg <= cyc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch sequencer
    typedef enum logic [1:0] {
        IFT_ST_FIRST,
        IFT_ST_SECOND,
        IFT_ST_FLUSH
    } ift_state_e;

    ift_state_e st_reg;
    ift_state_e st_next;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic [1:0] flush_reg;
    logic [1:0] flush_next;
    logic [15:0] first_word;
    logic hold_wr;
    logic wrap;
    logic [15:0] w;
    logic dw_first;
    logic skip_or_jump;
    logic [7:0] hi;
    logic dw_branch;

    assign wrap = (phase_reg == PHASE_LAST);
    assign w = instr_word_in;
    assign hi = w[15:8];

    ift_word_reg u_hold (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(hold_wr),
        .wr_data_in(instr_word_in),
        .rd_data_out(first_word)
    );

    // the four double-word openers: two-file move, call, goto, pointer load
    always_comb begin
        dw_first = (w[15:12] == 4'hc) || (hi[7:1] == 7'h76) || (hi == 8'hef)
            || (w[15:6] == 10'h3b8); // [RULE_02] [RULE_10]
        // call and goto openers held from the first word; both always take effect
        dw_branch = (first_word[15:8] == 8'hef) || (first_word[15:9] == 7'h76);
        // control transfers and skips burn an extra cycle when they take effect
        skip_or_jump = (w[15:12] == 4'hd) || (w[15:11] == 5'h1c && cond_true_in)
            || (w[15:12] == 4'he && cond_true_in) || (w[15:12] == 4'hb && cond_true_in)
            || (w[15:12] == 4'ha && cond_true_in) || (w[15:1] == 15'h0009)
            || (w[15:1] == 15'h0008) || (w == 16'h0012); // [RULE_12]
    end

    always_comb begin
        st_next = st_reg;
        pc_next = pc_reg;
        flush_next = flush_reg;
        hold_wr = 1'b0;
        if (wrap) begin // [RULE_20]
            case (st_reg)
                IFT_ST_FIRST: begin
                    pc_next = pc_reg + 21'h2;
                    if (dw_first) begin
                        hold_wr = 1'b1;
                        st_next = IFT_ST_SECOND; // [RULE_13]
                    end else if (skip_or_jump) begin
                        flush_next = 2'h1;
                        st_next = IFT_ST_FLUSH;
                    end
                end
                IFT_ST_SECOND: begin
                    pc_next = pc_reg + 21'h2;
                    // a taken branch-type double word adds a flush cycle
                    if (dw_branch) begin
                        flush_next = 2'h1;
                        st_next = IFT_ST_FLUSH; // [RULE_15]
                    end else begin
                        st_next = IFT_ST_FIRST;
                    end
                end
                IFT_ST_FLUSH: begin
                    pc_next = pc_reg + 21'h2;
                    flush_next = flush_reg - 2'h1;
                    if (flush_reg == 2'h1) begin
                        st_next = IFT_ST_FIRST;
                    end
                end
                default: st_next = IFT_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= IFT_ST_FIRST;
            pc_reg <= 21'h0;
            flush_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            pc_reg <= pc_next;
            flush_reg <= flush_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field split of the word being executed
    logic [15:0] ex;
    ift_group_e grp;
    logic [19:0] lit;
    logic nop_d;
    logic ext_d;
    logic [1:0] cyc_d;
    logic dw_d;

    always_comb begin
        ex = (st_reg == IFT_ST_FLUSH) ? NOP_WORD : w;
        // a bare second word decodes as no-operation
        nop_d = (st_reg == IFT_ST_FLUSH) || (ex == NOP_WORD)
            || (st_reg == IFT_ST_FIRST && w[15:12] == SECOND_WORD_MARK); // [RULE_11]
        dw_d = (st_reg == IFT_ST_SECOND);
        // extended group: 0xe8..0xeb plus 0x0014; a flushed word never flags it
        ext_d = (ex[15:8] == 8'he8) || (ex[15:8] == 8'he9) || (ex[15:8] == 8'hea) || (ex[15:8] == 8'heb)
            || (ex == 16'h0014); // [RULE_01]
        if (ex[15:12] >= 4'h7 && ex[15:12] <= 4'hb) begin
            grp = IFT_GRP_BIT; // [RULE_04] [RULE_07]
        end else if (ex[15:12] == 4'h0 && ex[11:8] != 4'h0 && ex[11:8] != 4'h1) begin
            grp = IFT_GRP_LITERAL; // [RULE_08]
        end else if (ex[15:12] >= 4'hd || ex[15:8] == 8'h00 || dw_d) begin
            grp = IFT_GRP_CONTROL; // [RULE_09]
        end else begin
            grp = IFT_GRP_BYTE; // [RULE_05]
        end
        // second word supplies the upper literal bits
        lit = dw_d ? {w[11:0], first_word[7:0]} : {12'h000, ex[7:0]};
        if (dw_d && dw_branch) begin
            cyc_d = 2'h3; // [RULE_15]
        end else if (dw_d) begin
            cyc_d = 2'h2;
        end else if (skip_or_jump && st_reg == IFT_ST_FIRST) begin
            cyc_d = 2'h2;
        end else begin
            cyc_d = 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered decode outputs, updated at each instruction cycle wrap except when the first word of a double word is fetched
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            group_out <= IFT_GRP_CONTROL;
            opcode_out <= 8'h00;
            file_addr_out <= 8'h00;
            dest_file_out <= 1'b0;
            bank_sel_out <= 1'b0;
            bit_num_out <= 3'h0;
            fsr_sel_out <= 2'h0;
            literal_out <= 20'h00000;
            fast_out <= 1'b0;
            tbl_mode_out <= IFT_TBL_NONE;
            two_word_out <= 1'b0;
            is_nop_out <= 1'b1;
            extended_out <= 1'b0;
            exec_cycles_out <= 2'h1;
        end else if (wrap && st_reg != IFT_ST_FIRST || wrap && !dw_first) begin
            valid_out <= 1'b1;
            group_out <= grp;
            opcode_out <= dw_d ? first_word[15:8] : ex[15:8]; // [RULE_03]
            file_addr_out <= ex[7:0]; // [RULE_17]
            dest_file_out <= ex[9]; // [RULE_06]
            bank_sel_out <= ex[8]; // [RULE_16]
            bit_num_out <= ex[11:9];
            fsr_sel_out <= dw_d ? first_word[5:4] : ex[5:4]; // [RULE_17]
            literal_out <= lit;
            fast_out <= dw_d ? first_word[8] : ex[0]; // [RULE_19]
            tbl_mode_out <= ift_tbl_e'(ex[1:0]); // [RULE_18]
            two_word_out <= dw_d;
            is_nop_out <= nop_d;
            extended_out <= ext_d;
            exec_cycles_out <= cyc_d; // [RULE_12] [RULE_13]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_addr_out <= 21'h0;
            phase_out <= 2'h0;
        end else begin
            fetch_addr_out <= pc_next;
            phase_out <= phase_next;
        end
    end

    assign cycle_strobe_out = cyc_reg;
endmodule
`default_nettype wire

/* hw/ift_pkg.sv */
// Contract
// [RULE_01] decode the 75 base instructions plus the eight extended software-stack instructions
// [RULE_02] most instructions are one 16-bit word; exactly four take two words
// [RULE_03] a single word splits into an opcode field and operand fields
// [RULE_04] every instruction falls in the byte, bit, literal or control group
// [RULE_05] byte instructions carry file address, destination bit and access bit
// [RULE_06] destination bit 0 writes the working register, 1 writes the file register
// [RULE_07] bit instructions carry file address, bit number and access bit
// [RULE_08] literal instructions carry a constant, optionally a pointer selector, or nothing
// [RULE_09] control instructions carry an address, call/return mode, table mode, or nothing
// [RULE_10] double-word instructions span 32 bits; second word has top four bits set
// [RULE_11] a lone second word executes as a no-operation
// [RULE_12] single-word takes one cycle, two when a test is true or pc changes
// [RULE_13] double-word instructions take two instruction cycles
// [RULE_14] one instruction cycle is four oscillator periods
// [RULE_15] a taken two-word branch takes three instruction cycles
// [RULE_16] access bit 0 uses the fixed access region, 1 uses the bank select register
// [RULE_17] file field is an 8-bit address or a 2-bit pointer selector
// [RULE_18] table mode: no change, post-increment, post-decrement, pre-increment
// [RULE_19] call/return mode 1 uses shadow copies, 0 leaves them alone
// [RULE_20] free-running modulo-four phase counter, cleared at reset, steps state on wrap
package ift_pkg;
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [3:0] SECOND_WORD_MARK = 4'hf;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef enum logic [1:0] {
        IFT_GRP_BYTE,
        IFT_GRP_BIT,
        IFT_GRP_LITERAL,
        IFT_GRP_CONTROL
    } ift_group_e;

    typedef enum logic [1:0] {
        IFT_TBL_NONE,
        IFT_TBL_POST_INC,
        IFT_TBL_POST_DEC,
        IFT_TBL_PRE_INC
    } ift_tbl_e;
endpackage

/* hw/ift_word_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// holds the first word of a double-word instruction while its second word is fetched
module ift_word_reg (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [15:0] wr_data_in,
    output logic [15:0] rd_data_out
);
    import ift_pkg::*;
    logic [15:0] mem_reg;
    logic [15:0] mem_next;

    always_comb begin
        mem_next = wr_en_in ? wr_data_in : mem_reg;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_reg <= RESET_WORD;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_data_out = mem_reg;
endmodule
`default_nettype wire

/* tb/ift_decoder_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ift_decoder_monitor (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [20:0] fetch_addr_out,
    input wire logic cycle_strobe_out,
    input wire logic [1:0] phase_out,
    input wire logic valid_out,
    input wire ift_pkg::ift_group_e group_out,
    input wire logic [7:0] opcode_out,
    input wire logic dest_file_out,
    input wire logic bank_sel_out,
    input wire logic [2:0] bit_num_out,
    input wire logic [19:0] literal_out,
    input wire logic two_word_out,
    input wire logic is_nop_out,
    input wire logic [1:0] exec_cycles_out
);
    import ift_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_phase_wrap;
        phase_out == 2'h3 |=> phase_out == 2'h0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");
    property p_strobe_period;
        $rose(cycle_strobe_out) |=> !cycle_strobe_out [*3] ##1 cycle_strobe_out;
    endproperty
    a_strobe_period: assert property (p_strobe_period) else $error("strobe not every 4 clocks");
    property p_decode_hold;
        phase_out != 2'h0 |-> $stable(opcode_out) && $stable(group_out) && $stable(literal_out);
    endproperty
    a_decode_hold: assert property (p_decode_hold) else $error("decode changed mid cycle");
    property p_fetch_step;
        $changed(fetch_addr_out) |-> phase_out == 2'h0;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("fetch moved off wrap");
    property p_two_word;
        valid_out && two_word_out |-> exec_cycles_out inside {2'h2, 2'h3};
    endproperty
    a_two_word: assert property (p_two_word) else $error("double word cycle count");
    property p_lone_nop;
        is_nop_out |-> exec_cycles_out == 2'h1 && !two_word_out;
    endproperty
    a_lone_nop: assert property (p_lone_nop) else $error("nop cycle count");
    // the d and a bits sit in the low two bits of the upper byte
    property p_byte_fields;
        valid_out && group_out == IFT_GRP_BYTE && !two_word_out && !is_nop_out
            |-> dest_file_out == opcode_out[1] && bank_sel_out == opcode_out[0];
    endproperty
    a_byte_fields: assert property (p_byte_fields) else $error("byte operand fields");
    property p_bit_fields;
        valid_out && group_out == IFT_GRP_BIT |-> bit_num_out == opcode_out[3:1] && bank_sel_out == opcode_out[0];
    endproperty
    a_bit_fields: assert property (p_bit_fields) else $error("bit operand fields");
endmodule
bind ift_decoder ift_decoder_monitor u_mon (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .fetch_addr_out(fetch_addr_out),
    .cycle_strobe_out(cycle_strobe_out), .phase_out(phase_out), .valid_out(valid_out), .group_out(group_out),
    .opcode_out(opcode_out), .dest_file_out(dest_file_out), .bank_sel_out(bank_sel_out), .bit_num_out(bit_num_out),
    .literal_out(literal_out), .two_word_out(two_word_out), .is_nop_out(is_nop_out),
    .exec_cycles_out(exec_cycles_out));
`default_nettype wire

/* tb/ift_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// program memory seen by the decoder; the testbench loads mem before reset is released
module ift_prog_mem (
    input wire logic [20:0] addr_in,
    output logic [15:0] word_out
);
    logic [15:0] mem [0:63];
    // word addressed, bit 0 of the byte address is ignored like a real word fetch
    assign word_out = mem[addr_in[6:1]];
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ift_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cond_true_in = 1'b0;
    logic [15:0] instr_word_in;
    logic [20:0] fetch_addr_out;
    logic [19:0] literal_out;
    logic [7:0] opcode_out, file_addr_out;
    logic [2:0] bit_num_out;
    logic [1:0] phase_out, fsr_sel_out, exec_cycles_out;
    logic cycle_strobe_out, valid_out, dest_file_out, bank_sel_out, fast_out, two_word_out, is_nop_out, extended_out;
    ift_group_e group_out;
    ift_tbl_e tbl_mode_out;
    int n_errors = 0;
    int num_checks = 0;
    always #2.5 mclk_in = ~mclk_in;
    ift_decoder dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_word_in(instr_word_in),
        .cond_true_in(cond_true_in), .fetch_addr_out(fetch_addr_out), .cycle_strobe_out(cycle_strobe_out),
        .phase_out(phase_out), .valid_out(valid_out), .group_out(group_out), .opcode_out(opcode_out),
        .file_addr_out(file_addr_out), .dest_file_out(dest_file_out), .bank_sel_out(bank_sel_out),
        .bit_num_out(bit_num_out), .fsr_sel_out(fsr_sel_out), .literal_out(literal_out), .fast_out(fast_out),
        .tbl_mode_out(tbl_mode_out), .two_word_out(two_word_out), .is_nop_out(is_nop_out),
        .extended_out(extended_out), .exec_cycles_out(exec_cycles_out));
    ift_prog_mem pm (.addr_in(fetch_addr_out), .word_out(instr_word_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string name, input logic [20:0] exp, input logic [20:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // waits for the next instruction cycle wrap edge (no new decode after a double word's first word), bounded to two instruction cycles
    task automatic next_dec;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_in);
            #1;
            if (phase_out === 2'h0) break;
        end
    endtask
    task automatic stop_test;
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_byte;
        next_dec;
        cmp("fetch", 21'h2, fetch_addr_out);
        cmp("group", IFT_GRP_BYTE, group_out);
        cmp("opcode", 21'h26, opcode_out);
        cmp("file", 21'h15, file_addr_out);
        cmp("dest", 21'h1, dest_file_out);
        cmp("bank", 21'h0, bank_sel_out);
        cmp("cycles", 21'h1, exec_cycles_out);
        next_dec;
        cmp("dest", 21'h0, dest_file_out);
        cmp("bank", 21'h1, bank_sel_out);
    endtask
    task automatic t_bit_lit_nop;
        next_dec;
        cmp("group", IFT_GRP_BIT, group_out);
        cmp("bitnum", 21'h3, bit_num_out);
        cmp("file", 21'ha3, file_addr_out);
        next_dec;
        cmp("group", IFT_GRP_LITERAL, group_out);
        cmp("literal", 21'h5a, literal_out);
        next_dec;
        cmp("nop", 21'h1, is_nop_out);
    endtask
    task automatic t_goto;
        next_dec;
        next_dec;
        cmp("group", IFT_GRP_CONTROL, group_out);
        cmp("twoword", 21'h1, two_word_out);
        cmp("literal", 21'h10, literal_out);
        cmp("cycles", 21'h3, exec_cycles_out);
        next_dec;
        cmp("nop", 21'h1, is_nop_out);
    endtask
    // a true skip test turns the following word into a no-operation cycle
    task automatic t_skip;
        cond_true_in = 1'b1;
        next_dec;
        cmp("opcode", 21'hb2, opcode_out);
        cmp("cycles", 21'h2, exec_cycles_out);
        cond_true_in = 1'b0;
        next_dec;
        cmp("nop", 21'h1, is_nop_out);
        next_dec;
        cmp("literal", 21'h77, literal_out);
    endtask
    // table read, fast return, pointer load and an extended opcode in a row
    task automatic t_fields;
        next_dec;
        cmp("valid", 21'h1, valid_out);
        cmp("strobe", 21'h1, cycle_strobe_out);
        cmp("group", IFT_GRP_CONTROL, group_out);
        cmp("tblmode", IFT_TBL_POST_DEC, tbl_mode_out);
        cmp("fast", 21'h0, fast_out);
        cmp("extended", 21'h0, extended_out);
        next_dec;
        cmp("fast", 21'h1, fast_out);
        cmp("cycles", 21'h2, exec_cycles_out);
        next_dec;
        cmp("nop", 21'h1, is_nop_out);
        next_dec;
        next_dec;
        cmp("twoword", 21'h1, two_word_out);
        cmp("fsrsel", 21'h1, fsr_sel_out);
        cmp("literal", 21'h0ab10, literal_out);
        cmp("cycles", 21'h2, exec_cycles_out);
        next_dec;
        cmp("extended", 21'h1, extended_out);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 64; i++)
            pm.mem[i] = 16'h0000;
        pm.mem[0] = 16'h2615;
        pm.mem[1] = 16'h2555;
        pm.mem[2] = 16'h87a3;
        pm.mem[3] = 16'h0e5a;
        pm.mem[4] = 16'hf123;
        pm.mem[5] = 16'hef10;
        pm.mem[6] = 16'hf000;
        pm.mem[8] = 16'hb201;
        pm.mem[9] = 16'h2615;
        pm.mem[10] = 16'h0e77;
        pm.mem[11] = 16'h000a;
        pm.mem[12] = 16'h0013;
        pm.mem[14] = 16'hee10;
        pm.mem[15] = 16'hf0ab;
        pm.mem[16] = 16'he8c3;
        repeat (2) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        cmp("phase", 21'h0, phase_out);
        cmp("valid", 21'h0, valid_out);
        cmp("nop", 21'h1, is_nop_out);
        cmp("cycles", 21'h1, exec_cycles_out);
        t_byte;
        t_bit_lit_nop;
        t_goto;
        t_skip;
        t_fields;
        stop_test;
    end
    initial begin
        #2000;
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
